// >>> logic/line_supervisor.sv
// line voltage supervisor: zero crossing, timeout, period, supply and sag watch
// assumes filtered voltage samples and register strobes arrive synchronous to core_clk_i
`timescale 1ns/1ps
module line_supervisor import line_supervisor_pkg::*; #(
	parameter int FILT_SHIFT = 2
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire reg_req_t reg_req_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic sample_valid_i,
	input wire logic signed [SAMPLE_W-1:0] sample_i,
	input wire logic supply_low_i,
	output logic zero_cross_out_o,
	output logic sag_n_o,
	output logic irq_n_o,
	output logic inactive_o,
	output logic integrator_en_o
);
	generate
		if (FILT_SHIFT < 0 || FILT_SHIFT > 8) begin : g_bad
			$error("FILT_SHIFT must lie in 0..8");
		end
	endgenerate

	// ==========================================================
	// reset release
	logic rst_meta_ff;
	logic rst_n;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	// ==========================================================
	// register strobes
	logic [11:0] timeout_ff;
	logic [7:0] sag_lvl_ff;
	logic [7:0] sag_cyc_ff;
	logic sag_dis_ff;
	logic [2:0] irq_en_ff;
	logic [7:0] trim_ff;
	logic [15:0] line_period_ff;
	event_t status_ff;
	event_t nxt_status;
	event_t ev;

	wire wr_timeout = reg_req_i.wr && (reg_req_i.addr == ADDR_TIMEOUT);
	wire wr_sag_lvl = reg_req_i.wr && (reg_req_i.addr == ADDR_SAG_LVL);
	wire wr_sag_cyc = reg_req_i.wr && (reg_req_i.addr == ADDR_SAG_CYC);
	wire wr_mode = reg_req_i.wr && (reg_req_i.addr == ADDR_MODE);
	wire wr_irq_en = reg_req_i.wr && (reg_req_i.addr == ADDR_IRQ_EN);
	wire wr_trim = reg_req_i.wr && (reg_req_i.addr == ADDR_OFFSET_TRIM);
	wire status_clr_rd = reg_req_i.rd && (reg_req_i.addr == ADDR_STATUS_CLR);

	// read mux, unmapped addresses answer zero
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		case (reg_req_i.addr)
			ADDR_TIMEOUT: rd_mux = {4'h0, timeout_ff};
			ADDR_PERIOD: rd_mux = line_period_ff;
			ADDR_SAG_LVL: rd_mux = {8'h00, sag_lvl_ff};
			ADDR_SAG_CYC: rd_mux = {8'h00, sag_cyc_ff};
			ADDR_MODE: rd_mux = {15'h0000, sag_dis_ff};
			ADDR_IRQ_EN: rd_mux = {13'h0000, irq_en_ff};
			ADDR_STATUS: rd_mux = {13'h0000, status_ff};
			ADDR_STATUS_CLR: rd_mux = {13'h0000, status_ff};
			ADDR_OFFSET_TRIM: rd_mux = {8'h00, trim_ff};
			default: rd_mux = '0;
		endcase
	end

	// writable registers; integrator is off until trim top bit is written
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			timeout_ff <= TIMEOUT_RST;
			sag_lvl_ff <= SAG_LVL_RST;
			sag_cyc_ff <= SAG_CYC_RST;
			sag_dis_ff <= 1'b0;
			irq_en_ff <= IRQ_EN_RST;
			trim_ff <= TRIM_RST;
			reg_rdata_o <= '0;
			reg_rvalid_o <= 1'b0;
		end else begin
			if (wr_timeout) timeout_ff <= reg_req_i.wdata[11:0];
			if (wr_sag_lvl) sag_lvl_ff <= reg_req_i.wdata[7:0];
			if (wr_sag_cyc) sag_cyc_ff <= reg_req_i.wdata[7:0];
			if (wr_mode) sag_dis_ff <= reg_req_i.wdata[MODE_SAG_DIS];
			if (wr_irq_en) irq_en_ff <= reg_req_i.wdata[2:0];
			if (wr_trim) trim_ff <= reg_req_i.wdata[7:0];
			if (reg_req_i.rd) reg_rdata_o <= rd_mux;
			reg_rvalid_o <= reg_req_i.rd;
		end
	end
	assign integrator_en_o = trim_ff[TRIM_INT_EN];

	// ==========================================================
	// zero crossing from the lowpass sample sign
	logic pos_ff;
	wire sample_neg = sample_i[SAMPLE_W-1];
	wire zx_rise = sample_valid_i && !sample_neg && !pos_ff;
	wire zx_fall = sample_valid_i && sample_neg && pos_ff;
	wire zx_any = zx_rise || zx_fall;

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pos_ff <= 1'b0;
		end else if (zx_any) begin
			pos_ff <= zx_rise;
		end
	end
	assign zero_cross_out_o = pos_ff;

	// ==========================================================
	// zero crossing timeout, one step per 128 clocks
	logic tick_tout;
	logic tick_per;
	tick_divider #(.DIV(TIMEOUT_TICK)) u_tick_tout (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n),
		.tick_o(tick_tout)
	);
	tick_divider #(.DIV(PERIOD_TICK)) u_tick_per (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n),
		.tick_o(tick_per)
	);

	logic [11:0] tout_cnt_ff;
	logic tout_sag_ff;
	wire tout_reload = zx_any || wr_timeout;
	wire tout_hit = tick_tout && !tout_reload && (tout_cnt_ff == TOUT_LAST);

	// a host write also reloads with the new value; a crossing in the same cycle wins and reloads the old timeout_ff value
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tout_cnt_ff <= TIMEOUT_RST;
		end else if (zx_any) begin
			tout_cnt_ff <= timeout_ff;
		end else if (wr_timeout) begin
			tout_cnt_ff <= reg_req_i.wdata[11:0];
		end else if (tick_tout && tout_cnt_ff != '0) begin
			tout_cnt_ff <= tout_cnt_ff - 12'h001;
		end
	end

	// sag output hold for missing crossings, released by the next crossing
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tout_sag_ff <= 1'b0;
		end else if (zx_any) begin
			tout_sag_ff <= 1'b0;
		end else if (tout_hit && !sag_dis_ff) begin
			tout_sag_ff <= 1'b1;
		end
	end

	// ==========================================================
	// line period: clocks / 8 between rising crossings, smoothed
	logic [15:0] per_cnt_ff;
	wire signed [16:0] per_diff = $signed({1'b0, per_cnt_ff}) - $signed({1'b0, line_period_ff});
	wire signed [16:0] per_step = per_diff >>> FILT_SHIFT;
	wire [15:0] nxt_period = line_period_ff + per_step[15:0];

	// counter saturates so a very slow line cannot wrap into a short period
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			per_cnt_ff <= '0;
			line_period_ff <= '0;
		end else if (zx_rise) begin
			per_cnt_ff <= '0;
			line_period_ff <= nxt_period & PERIOD_MAX;
		end else if (tick_per && per_cnt_ff != PERIOD_MAX) begin
			per_cnt_ff <= per_cnt_ff + 16'h0001;
		end
	end

	// ==========================================================
	// sag detection on the doubled magnitude top byte
	wire [15:0] mag_full = sample_neg ? 16'(-sample_i) : sample_i;
	wire [7:0] mag_byte = mag_full[14:7];
	wire above_lvl = sample_valid_i && !(sag_lvl_ff > mag_byte);
	// host must keep the cycle count at two or more; smaller is treated as two
	wire [7:0] cyc_eff = (sag_cyc_ff < SAG_CYC_MIN) ? SAG_CYC_MIN : sag_cyc_ff;
	wire [7:0] cyc_goal = cyc_eff - 8'h01;

	sag_state_t sag_state_ff;
	sag_state_t nxt_sag_state;
	logic [7:0] low_cyc_ff;
	logic [7:0] nxt_low_cyc;
	logic enter_low;

	always_comb begin
		nxt_sag_state = sag_state_ff;
		nxt_low_cyc = low_cyc_ff;
		enter_low = 1'b0;
		case (sag_state_ff)
			SAG_IDLE: begin
				if (sample_valid_i && !above_lvl) begin
					nxt_sag_state = SAG_COUNT;
					nxt_low_cyc = '0;
				end
			end
			SAG_COUNT: begin
				if (above_lvl) begin
					nxt_sag_state = SAG_IDLE;
				end else if (zx_rise) begin
					nxt_low_cyc = low_cyc_ff + 8'h01;
					if (nxt_low_cyc >= cyc_goal) begin
						nxt_sag_state = SAG_LOW;
						enter_low = 1'b1;
					end
				end
			end
			SAG_LOW: begin
				if (above_lvl) nxt_sag_state = SAG_IDLE;
			end
			default: nxt_sag_state = SAG_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sag_state_ff <= SAG_IDLE;
			low_cyc_ff <= '0;
		end else begin
			sag_state_ff <= nxt_sag_state;
			low_cyc_ff <= nxt_low_cyc;
		end
	end

	// ==========================================================
	// sag pin, supply state
	wire sag_active = supply_low_i
		|| (!sag_dis_ff && (nxt_sag_state == SAG_LOW))
		|| (!sag_dis_ff && tout_sag_ff);

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sag_n_o <= 1'b1;
			inactive_o <= 1'b0;
		end else begin
			sag_n_o <= !sag_active;
			inactive_o <= supply_low_i;
		end
	end

	// ==========================================================
	// status flags and interrupt; a new event wins over the clearing read
	assign ev = '{zx: zx_any,
		tout: tout_hit,
		sag: enter_low && !sag_dis_ff};
	assign nxt_status = (status_clr_rd ? event_t'(3'h0) : status_ff) | ev;

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			status_ff <= '0;
			irq_n_o <= 1'b1;
		end else begin
			status_ff <= nxt_status;
			irq_n_o <= !(|(nxt_status & irq_en_ff));
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);

	chk_zx_rise_high: assert property (zx_rise |=> zero_cross_out_o)
		else $error("zero cross output not high after rising crossing");
	chk_zx_fall_low: assert property (zx_fall |=> !zero_cross_out_o ##1 (!zero_cross_out_o || $past(zx_rise)))
		else $error("zero cross output not low after falling crossing");
	chk_zx_flag_set: assert property (zx_any |=> status_ff.zx)
		else $error("zero cross flag not set");
	chk_clear_read: assert property ((status_clr_rd && ev == 3'h0) |=> (status_ff == 3'h0) && irq_n_o)
		else $error("clearing read left flags or interrupt active");
	chk_irq_zx_en: assert property ((zx_any && irq_en_ff[ST_ZX]) |=> !irq_n_o)
		else $error("enabled zero cross did not pull interrupt");
	chk_irq_masked: assert property ((irq_en_ff == 3'h0) |=> irq_n_o)
		else $error("interrupt low with all enables off");
	chk_tout_step: assert property ((!tick_tout && !tout_reload) |=> $stable(tout_cnt_ff))
		else $error("timeout counter moved without a tick");
	chk_tout_reload: assert property ((zx_any && !wr_timeout) |=> tout_cnt_ff == $past(timeout_ff))
		else $error("timeout counter not reloaded on crossing");
	chk_tout_flag: assert property (tout_hit |=> status_ff.tout ##1 (status_ff.tout || $past(status_clr_rd)))
		else $error("timeout flag not set");
	chk_tout_sag_pin: assert property ((tout_hit && !sag_dis_ff && !zx_any) |=> ##1 !sag_n_o)
		else $error("timeout did not pull sag output");
	chk_supply_sag: assert property (supply_low_i |=> !sag_n_o && inactive_o)
		else $error("inactive supply state not shown on sag output");
	chk_period_msb: assert property (!line_period_ff[15])
		else $error("line period top bit set");
	chk_sag_release: assert property ((above_lvl && !supply_low_i && !tout_sag_ff && !tout_hit) |=> sag_n_o)
		else $error("sag output not released above level");
	chk_sag_flag: assert property ((enter_low && !sag_dis_ff) |=> status_ff.sag)
		else $error("sag flag not set on sag event");
	chk_integrator_on: assert property ((wr_trim && reg_req_i.wdata[TRIM_INT_EN]) |=> integrator_en_o)
		else $error("integrator not enabled by trim write");

	cov_rise: cover property (zx_rise ##[1:1000] zx_fall);
	cov_timeout: cover property (tout_hit);
	cov_sag: cover property (enter_low);
	cov_clear: cover property (status_clr_rd && status_ff != 3'h0);
endmodule

// >>> logic/line_supervisor_pkg.sv
// constants, register map and shared types of the line voltage supervisor
// assumes a single 125 MHz core clock and a register strobe port from the serial front end
package line_supervisor_pkg;

	// ==========================================================
	// widths
	localparam int SAMPLE_W = 16;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;

	// ==========================================================
	// register map
	localparam logic [5:0] ADDR_TIMEOUT = 6'h1D;
	localparam logic [5:0] ADDR_PERIOD = 6'h20;
	localparam logic [5:0] ADDR_SAG_LVL = 6'h21;
	localparam logic [5:0] ADDR_SAG_CYC = 6'h22;
	localparam logic [5:0] ADDR_MODE = 6'h23;
	localparam logic [5:0] ADDR_IRQ_EN = 6'h24;
	localparam logic [5:0] ADDR_STATUS = 6'h25;
	localparam logic [5:0] ADDR_STATUS_CLR = 6'h26;
	localparam logic [5:0] ADDR_OFFSET_TRIM = 6'h27;

	// ==========================================================
	// reset values
	localparam logic [11:0] TIMEOUT_RST = 12'hFFF;
	localparam logic [7:0] SAG_LVL_RST = 8'h00;
	localparam logic [7:0] SAG_CYC_RST = 8'hFF;
	localparam logic [7:0] TRIM_RST = 8'h00;
	localparam logic [2:0] IRQ_EN_RST = 3'h0;

	// ==========================================================
	// field positions
	localparam int ST_ZX = 0;
	localparam int ST_TOUT = 1;
	localparam int ST_SAG = 2;
	localparam int MODE_SAG_DIS = 0;
	localparam int TRIM_INT_EN = 7;
	localparam int TRIM_VAL_W = 6;

	// ==========================================================
	// timing
	localparam int TIMEOUT_TICK = 128;
	localparam int PERIOD_TICK = 8;
	localparam logic [15:0] PERIOD_MAX = 16'h7FFF;
	localparam logic [11:0] TOUT_LAST = 12'h001;
	localparam logic [7:0] SAG_CYC_MIN = 8'h02;

	// ==========================================================
	// types
	typedef struct packed {
		logic sag;
		logic tout;
		logic zx;
	} event_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		SAG_IDLE = 2'b00,
		SAG_COUNT = 2'b01,
		SAG_LOW = 2'b11
	} sag_state_t;

endpackage

// >>> logic/tick_divider.sv
// free running divider giving a one-cycle tick every DIV clocks
// assumes a synchronised active-low reset from the instantiating block
`timescale 1ns/1ps
module tick_divider import line_supervisor_pkg::*; #(
	parameter int DIV = 128
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	output logic tick_o
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	generate
		if (DIV < 2) begin : g_bad
			$error("tick_divider needs DIV of at least 2");
		end
	endgenerate

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	wire at_last = (cnt_ff == LAST);

	assign nxt_cnt = at_last ? '0 : cnt_ff + CW'(1);
	assign tick_o = at_last;

	// ==========================================================
	// counter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

// >>> testbench/host_model.sv
// host side model: drives register strobes toward the line supervisor
// assumes the bench clock and the one-cycle strobe timing of the serial front end
`timescale 1ns/1ps
module host_model import line_supervisor_pkg::*; (
	input wire logic clk_i,
	input wire logic [DATA_W-1:0] reg_rdata_i,
	input wire logic reg_rvalid_i,
	output reg_req_t reg_req_o
);
	// ==========================================================
	// register access
	// idle strobes low from time zero
	initial begin
		reg_req_o = '0;
	end

	// one write strobe; a sag cycle count below two is never sent
	task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] v;
		v = d;
		if (a == ADDR_SAG_CYC && d < 16'h0002) begin
			v = 16'h0002;
		end
		@(posedge clk_i);
		#1;
		reg_req_o.wr = 1'b1;
		reg_req_o.addr = a;
		reg_req_o.wdata = v;
		@(posedge clk_i);
		#1;
		reg_req_o.wr = 1'b0;
		// released lines must not keep the old value
		reg_req_o.addr = ~a;
		reg_req_o.wdata = ~v;
	endtask

	// read strobe; data is only trusted with its valid pulse
	task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk_i);
		#1;
		reg_req_o.rd = 1'b1;
		reg_req_o.addr = a;
		@(posedge clk_i);
		#1;
		reg_req_o.rd = 1'b0;
		reg_req_o.addr = ~a;
		d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 'x;
	endtask
endmodule

// >>> testbench/line_supervisor_bench.sv
// self-checking bench for the line supervisor
// assumes the host model for register access and drives voltage samples itself
`timescale 1ns/1ps
module line_supervisor_bench import line_supervisor_pkg::*;;
	localparam logic [15:0] HI = 16'h2000;
	localparam logic [15:0] LO = 16'hE000;
	localparam int W = 398;
	localparam int PER = (2 * (2 + W)) / PERIOD_TICK;
	logic clk = 1'b0;
	logic nrst;
	logic valid;
	logic low;
	logic signed [15:0] smp_v;
	reg_req_t req;
	logic [15:0] rdata;
	logic rvalid, zx, sag_n, irq_n, inact, integ;
	logic [15:0] p;
	int fail_count = 0;
	int compares = 0;

	// ==========================================================
	// clock and instances
	always #4 clk = ~clk;

	line_supervisor #(.FILT_SHIFT(0)) dut_u (.core_clk_i(clk), .nrst_i(nrst), .reg_req_i(req),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .sample_valid_i(valid), .sample_i(smp_v),
		.supply_low_i(low), .zero_cross_out_o(zx), .sag_n_o(sag_n), .irq_n_o(irq_n),
		.inactive_o(inact), .integrator_en_o(integ));

	host_model host_u (.clk_i(clk), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_req_o(req));

	// ==========================================================
	// helpers
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask

	task automatic rc(input string n, input logic [5:0] a, input logic [15:0] e);
		logic [15:0] d;
		host_u.read_reg(a, d);
		chk(n, e, d);
	endtask

	// one filtered sample; the line is inverted once valid drops
	task automatic smp(input logic [15:0] v);
		@(posedge clk);
		#1;
		valid = 1'b1;
		smp_v = v;
		@(posedge clk);
		#1;
		valid = 1'b0;
		smp_v = ~v;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic complete_run;
		if (fail_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// watchdog sized well above the longest sequence
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run;
	end

	// ==========================================================
	// main sequence
	initial begin
		nrst = 1'b0;
		valid = 1'b0;
		low = 1'b0;
		smp_v = LO;
		cyc(10);
		nrst = 1'b1;
		cyc(3);
		// reset values, register access and integrator enable
		rc("timeout_rst", ADDR_TIMEOUT, 16'h0FFF);
		rc("unmapped", 6'h3F, 16'h0000);
		chk("integ_off", 16'h0000, {15'h0, integ});
		host_u.write_reg(ADDR_TIMEOUT, 16'h0123);
		rc("timeout_rw", ADDR_TIMEOUT, 16'h0123);
		host_u.write_reg(ADDR_TIMEOUT, 16'h0FFF);
		host_u.write_reg(ADDR_OFFSET_TRIM, 16'h0080);
		cyc(2);
		chk("integ_on", 16'h0001, {15'h0, integ});
		// crossings, flag, interrupt and clearing read
		host_u.write_reg(ADDR_IRQ_EN, 16'h0001);
		smp(LO);
		smp(HI);
		cyc(1);
		chk("zx_rise", 16'h0001, {15'h0, zx});
		chk("irq_zx", 16'h0000, {15'h0, irq_n});
		rc("st_clr_rise", ADDR_STATUS_CLR, 16'h0001);
		cyc(1);
		chk("irq_clr", 16'h0001, {15'h0, irq_n});
		rc("st_after_clr", ADDR_STATUS, 16'h0000);
		smp(LO);
		cyc(1);
		chk("zx_fall", 16'h0000, {15'h0, zx});
		rc("st_fall", ADDR_STATUS, 16'h0001);
		rc("st_fall_kept", ADDR_STATUS_CLR, 16'h0001);
		host_u.write_reg(ADDR_IRQ_EN, 16'h0000);
		smp(HI);
		cyc(1);
		chk("irq_masked", 16'h0001, {15'h0, irq_n});
		rc("st_masked", ADDR_STATUS_CLR, 16'h0001);
		// timeout with sag output enabled, then disabled
		for (int m = 0; m < 2; m++) begin
			host_u.write_reg(ADDR_MODE, 16'(m));
			host_u.write_reg(ADDR_IRQ_EN, 16'(m << 1));
			host_u.write_reg(ADDR_TIMEOUT, 16'h0002);
			cyc(100);
			rc("tout_early", ADDR_STATUS, 16'h0000);
			cyc(162);
			chk("sag_tout", 16'(m), {15'h0, sag_n});
			chk("irq_tout", 16'(1 - m), {15'h0, irq_n});
			rc("st_tout", ADDR_STATUS_CLR, 16'h0002);
			smp(m == 0 ? LO : HI);
			cyc(3);
			chk("sag_reload", 16'h0001, {15'h0, sag_n});
			host_u.read_reg(ADDR_STATUS_CLR, p);
		end
		host_u.write_reg(ADDR_MODE, 16'h0000);
		host_u.write_reg(ADDR_TIMEOUT, 16'h0FFF);
		// period over three line cycles of fixed length
		repeat (3) begin
			smp(LO);
			cyc(W);
			smp(HI);
			cyc(W);
		end
		host_u.read_reg(ADDR_PERIOD, p);
		chk("period_range", 16'h0001, 16'(p >= PER - 1 && p <= PER + 1));
		chk("period_msb", 16'h0000, {15'h0, p[15]});
		host_u.read_reg(ADDR_STATUS_CLR, p);
		// sag: magnitude 0x40 against level 0x41, four programmed cycles
		host_u.write_reg(ADDR_SAG_LVL, 16'h0041);
		host_u.write_reg(ADDR_SAG_CYC, 16'h0004);
		host_u.write_reg(ADDR_IRQ_EN, 16'h0004);
		smp(LO);
		smp(HI);
		smp(LO);
		smp(HI);
		cyc(3);
		chk("sag_early", 16'h0001, {15'h0, sag_n});
		smp(LO);
		smp(HI);
		cyc(3);
		chk("sag_low", 16'h0000, {15'h0, sag_n});
		chk("irq_sag", 16'h0000, {15'h0, irq_n});
		// equal magnitude is not below the level
		smp(16'h2080);
		cyc(3);
		chk("sag_release", 16'h0001, {15'h0, sag_n});
		rc("st_sag", ADDR_STATUS_CLR, 16'h0005);
		// supply monitor
		low = 1'b1;
		cyc(3);
		chk("inactive", 16'h0001, {15'h0, inact});
		chk("sag_supply", 16'h0000, {15'h0, sag_n});
		low = 1'b0;
		cyc(3);
		chk("sag_supply_off", 16'h0001, {15'h0, sag_n});
		complete_run;
	end
endmodule
